// ==== core/ortc_core.sv ====
// Summary of operation
// R1: Instructions are decoded only after the write address byte is acknowledged.
// R2: Hold freezes and clears the divider; the two prescaler bits keep running.
// R3: After hold release the first counter increment comes 32 seconds later.
// R4: After release the divider advances on the next 8192 Hz prescaler tick.
// R5: Oscillator loss outside deep sleep causes a full chip reset.
// R6: Deep sleep needs hold, load of AAAAAAh, sleep code, then STOP.
// R7: Sleep disable restarts the oscillator during its acknowledge; release follows.
// R8: Passthrough puts the oscillator on the wake pin instead of pulses.
// R9: Fast mode increments and pulses once per second instead of 32 seconds.
// R10: In fast mode the master finishes each access within one second.
// R11: Repeated START unfreezes the counter like a STOP.
// R12: Counter load updates only the bytes actually received.
// R13: Load takes three bytes, upper first; the next byte is an instruction.
// R14: Counting starts on the acknowledge of the divider release code.
// R15: Master should wait for a time marker between load and release.
// R16: Counter frozen during access; a pending increment applies afterward.
// R17: Read returns the three counter bytes cyclically until terminated.
// R18: Master ends a counter read within 32 seconds or a count drops.
// R19: Power-on reset lasts at most 10 ms with the bus unresponsive.
// R20: After reset all modes are off and the counter is zero.
// R21: A foreign slave address is ignored until the next START or STOP.
// R22: Read continues upper byte first while acknowledged; no acknowledge ends it.
// R23: Codes 31h and 30h switch oscillator passthrough on and off.
// R24: Codes 41h and 40h switch fast counting on and off.
// R25: Unknown instruction bytes are acknowledged and otherwise ignored.
`timescale 1ns/100ps
`include "ortc_defines.svh"
module ortc_core #(
  parameter int unsigned POR_CYCLES  = `ORTC_POR_CYCLES,
  parameter int unsigned LOSS_CYCLES = `ORTC_LOSS_CYCLES,
  parameter int unsigned SLOW_TICKS  = `ORTC_SLOW_TICKS,
  parameter int unsigned FAST_TICKS  = `ORTC_FAST_TICKS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        osc_in,
  output logic             osc_enable,
  output logic             wake_out
);

  ortc_pkg::ortc_bus_st_t state_q;
  logic                   scl_s;
  logic                   sda_s;
  logic                   osc_s;
  logic                   scl_prev_q;
  logic                   sda_prev_q;
  logic                   osc_prev_q;
  logic [3:0]             bit_cnt_q;
  logic [7:0]             shift_q;
  logic                   rd_mode_q;
  logic [1:0]             rd_idx_q;
  logic                   sda_oe_q;
  logic [1:0]             param_q;
  logic                   hold_q;
  logic                   sleep_q;
  logic                   sleep_arm_q;
  logic                   pass_q;
  logic                   fast_q;
  logic                   frozen_q;
  logic                   pend_q;
  logic [23:0]            count_q;
  logic [1:0]             pre_q;
  logic [17:0]            div_q;
  logic [17:0]            div_lim;
  logic                   int_q;
  logic                   wake_q;
  logic [31:0]            por_cnt_q;
  logic [31:0]            loss_cnt_q;
  logic                   loss_en_q;
  logic                   ack_q;
  logic [31:0]            rdata_q;
  logic                   por_busy;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_ev;
  logic                   stop_ev;
  logic                   byte_done;
  logic                   addr_ok;
  logic                   wbyte_ev;
  logic                   osc_rise;
  logic                   tick8k;
  logic                   tick_inc;
  logic                   loss_ev;
  logic [7:0]             tx_byte;

  ortc_sync #(.RESET_VAL(1'b1)) u_sync_scl (.clk(clk), .rst(rst), .d(scl_in), .q(scl_s));
  ortc_sync #(.RESET_VAL(1'b1)) u_sync_sda (.clk(clk), .rst(rst), .d(sda_in), .q(sda_s));
  ortc_sync #(.RESET_VAL(1'b0)) u_sync_osc (.clk(clk), .rst(rst), .d(osc_in), .q(osc_s));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      osc_prev_q <= 1'b0;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      osc_prev_q <= osc_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_q;
  assign scl_fall  = ~scl_s & scl_prev_q;
  assign start_ev  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_ev   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign byte_done = scl_fall & (bit_cnt_q == 4'h8) & ~start_ev & ~stop_ev & ~por_busy;
  assign addr_ok   = byte_done & (state_q == ortc_pkg::ORTC_ADDR)
                     & ((shift_q == `ORTC_ADDR_WR) | (shift_q == `ORTC_ADDR_RD));
  assign wbyte_ev  = byte_done & (state_q == ortc_pkg::ORTC_WDATA); // R1
  assign osc_rise  = osc_s & ~osc_prev_q;
  assign por_busy  = (por_cnt_q < POR_CYCLES);

  // Read data walk upper, middle, lower, then wrap
  always_comb
  begin
    case (rd_idx_q)
      2'h0:    tx_byte = count_q[23:16]; // R22
      2'h1:    tx_byte = count_q[15:8];
      default: tx_byte = count_q[7:0];
    endcase
  end

  // Serial slave; silent while the internal reset runs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q   <= ortc_pkg::ORTC_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      rd_mode_q <= 1'b0;
      rd_idx_q  <= 2'h0;
    end
    else if (por_busy)
    begin
      state_q <= ortc_pkg::ORTC_IDLE; // R19
    end
    else if (start_ev)
    begin
      state_q   <= ortc_pkg::ORTC_ADDR;
      bit_cnt_q <= 4'h0;
    end
    else if (stop_ev)
    begin
      state_q <= ortc_pkg::ORTC_IDLE;
    end
    else
    begin
      case (state_q)
        ortc_pkg::ORTC_ADDR, ortc_pkg::ORTC_WDATA:
        begin
          if (scl_rise && bit_cnt_q != 4'h8)
          begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_q <= 4'h0;
            if (state_q == ortc_pkg::ORTC_WDATA)
            begin
              state_q <= ortc_pkg::ORTC_ACK; // R25
            end
            else if (addr_ok)
            begin
              state_q   <= ortc_pkg::ORTC_ACK;
              rd_mode_q <= shift_q[0];
              rd_idx_q  <= 2'h0;
            end
            else
            begin
              state_q <= ortc_pkg::ORTC_IGNORE; // R21
            end
          end
        end
        ortc_pkg::ORTC_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= 4'h0;
            if (rd_mode_q)
            begin
              state_q <= ortc_pkg::ORTC_RDATA;
              shift_q <= tx_byte;
              rd_idx_q <= (rd_idx_q == 2'h2) ? 2'h0 : rd_idx_q + 2'h1;
            end
            else
            begin
              state_q <= ortc_pkg::ORTC_WDATA;
            end
          end
        end
        ortc_pkg::ORTC_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == 4'h7)
            begin
              state_q <= ortc_pkg::ORTC_RACK;
            end
            else
            begin
              shift_q   <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ortc_pkg::ORTC_RACK:
        begin
          if (scl_rise && sda_s)
          begin
            state_q <= ortc_pkg::ORTC_IGNORE; // R22
          end
          else if (scl_fall)
          begin
            state_q   <= ortc_pkg::ORTC_RDATA; // R17
            shift_q   <= tx_byte;
            bit_cnt_q <= 4'h0;
            rd_idx_q  <= (rd_idx_q == 2'h2) ? 2'h0 : rd_idx_q + 2'h1;
          end
        end
        ortc_pkg::ORTC_IDLE, ortc_pkg::ORTC_IGNORE:
        begin
          state_q <= state_q;
        end
        default:
        begin
          state_q <= ortc_pkg::ORTC_IDLE;
        end
      endcase
    end
  end

  // One clock behind the state; negligible against the bus bit time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_oe_q <= 1'b0;
    end
    else
    begin
      sda_oe_q <= (state_q == ortc_pkg::ORTC_ACK)
                  | ((state_q == ortc_pkg::ORTC_RDATA) & ~shift_q[7]);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_q;

  // Instruction decode and mode flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      param_q     <= 2'h0;
      hold_q      <= 1'b0;
      sleep_q     <= 1'b0;
      sleep_arm_q <= 1'b0;
      pass_q      <= 1'b0;
      fast_q      <= 1'b0;
    end
    else if (por_busy)
    begin
      param_q     <= 2'h0; // R20
      hold_q      <= 1'b0;
      sleep_q     <= 1'b0;
      sleep_arm_q <= 1'b0;
      pass_q      <= 1'b0;
      fast_q      <= 1'b0;
    end
    else
    begin
      if (addr_ok)
      begin
        param_q <= 2'h0;
      end
      else if (wbyte_ev && param_q != 2'h0)
      begin
        param_q <= (param_q == 2'h3) ? 2'h0 : param_q + 2'h1; // R13
      end
      else if (wbyte_ev)
      begin
        case (shift_q)
          `ORTC_CMD_HOLD_ON:  hold_q <= 1'b1; // R2
          `ORTC_CMD_HOLD_OFF: hold_q <= 1'b0; // R14
          `ORTC_CMD_SLP_ON:   sleep_arm_q <= hold_q & (count_q == `ORTC_SLEEP_VALUE); // R6
          `ORTC_CMD_SLP_OFF:
          begin
            sleep_q     <= 1'b0; // R7
            sleep_arm_q <= 1'b0;
          end
          `ORTC_CMD_PASS_ON:  pass_q <= 1'b1; // R23
          `ORTC_CMD_PASS_OFF: pass_q <= 1'b0;
          `ORTC_CMD_FAST_ON:  fast_q <= 1'b1; // R24
          `ORTC_CMD_FAST_OFF: fast_q <= 1'b0;
          `ORTC_CMD_LOAD:     param_q <= 2'h1;
          default:            param_q <= 2'h0; // R25
        endcase
      end
      if (stop_ev && sleep_arm_q)
      begin
        sleep_q     <= 1'b1; // R6
        sleep_arm_q <= 1'b0;
      end
    end
  end

  // Counter frozen from a valid address until START or STOP
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frozen_q <= 1'b0;
    end
    else if (por_busy || start_ev || stop_ev)
    begin
      frozen_q <= 1'b0; // R11
    end
    else if (addr_ok)
    begin
      frozen_q <= 1'b1; // R16
    end
  end

  // Prescaler runs through hold; divider cleared while held
  assign tick8k   = osc_rise & (pre_q == 2'h3);
  assign div_lim  = fast_q ? 18'(FAST_TICKS - 1) : 18'(SLOW_TICKS - 1); // R9
  assign tick_inc = tick8k & ~hold_q & (div_q >= div_lim); // R3

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= 2'h0;
      div_q <= 18'h00000;
    end
    else if (por_busy)
    begin
      pre_q <= 2'h0;
      div_q <= 18'h00000;
    end
    else
    begin
      if (osc_rise)
      begin
        pre_q <= pre_q + 2'h1; // R2
      end
      if (hold_q)
      begin
        div_q <= 18'h00000; // R2
      end
      else if (tick_inc)
      begin
        div_q <= 18'h00000;
      end
      else if (tick8k)
      begin
        div_q <= div_q + 18'h00001; // R4
      end
    end
  end

  // Increment due while frozen waits; a second one is dropped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= `ORTC_COUNT_RESET;
      pend_q  <= 1'b0;
    end
    else if (por_busy)
    begin
      count_q <= `ORTC_COUNT_RESET; // R20
      pend_q  <= 1'b0;
    end
    else if (wbyte_ev && param_q != 2'h0)
    begin
      case (param_q)
        2'h1:    count_q[23:16] <= shift_q; // R12
        2'h2:    count_q[15:8]  <= shift_q;
        default: count_q[7:0]   <= shift_q;
      endcase
      pend_q <= pend_q | tick_inc;
    end
    else if (frozen_q)
    begin
      pend_q <= pend_q | tick_inc; // R16
    end
    else if (tick_inc || pend_q)
    begin
      count_q <= count_q + 24'h000001; // R16
      pend_q  <= 1'b0;
    end
  end

  // Wake pin: pulse lasts until the next rising oscillator edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_q  <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      if (tick_inc)
      begin
        int_q <= 1'b1; // R9
      end
      else if (osc_rise || por_busy)
      begin
        int_q <= 1'b0;
      end
      wake_q <= pass_q ? osc_s : int_q; // R8
    end
  end

  assign wake_out   = wake_q;
  assign osc_enable = ~sleep_q;

  // Missing oscillator edges outside sleep restart the internal reset
  assign loss_ev = loss_en_q & (loss_cnt_q >= LOSS_CYCLES);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      loss_cnt_q <= 32'h00000000;
      por_cnt_q  <= 32'h00000000;
    end
    else
    begin
      if (osc_rise || sleep_q || por_busy || !loss_en_q)
      begin
        loss_cnt_q <= 32'h00000000;
      end
      else
      begin
        loss_cnt_q <= loss_cnt_q + 32'h00000001;
      end
      if (loss_ev)
      begin
        por_cnt_q <= 32'h00000000; // R5
      end
      else if (por_busy)
      begin
        por_cnt_q <= por_cnt_q + 32'h00000001; // R19
      end
    end
  end

  // Avalon slave: every access answers on the second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h00000000;
      loss_en_q <= `ORTC_CTRL_RESET;
    end
    else
    begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read && !ack_q)
      begin
        rdata_q <= 32'h00000000;
        case (avs_address)
          `ORTC_OFS_STATUS:
          begin
            rdata_q[`ORTC_ST_HOLD]   <= hold_q;
            rdata_q[`ORTC_ST_SLEEP]  <= sleep_q;
            rdata_q[`ORTC_ST_PASS]   <= pass_q;
            rdata_q[`ORTC_ST_FAST]   <= fast_q;
            rdata_q[`ORTC_ST_FROZEN] <= frozen_q;
            rdata_q[`ORTC_ST_POR]    <= por_busy;
          end
          `ORTC_OFS_COUNT: rdata_q[23:0] <= count_q;
          `ORTC_OFS_CTRL:  rdata_q[`ORTC_CTRL_LOSS_EN] <= loss_en_q;
          default:         rdata_q <= 32'h00000000;
        endcase
      end
      if (avs_write && ack_q && avs_address == `ORTC_OFS_CTRL && avs_byteenable[0])
      begin
        loss_en_q <= avs_writedata[`ORTC_CTRL_LOSS_EN];
      end
    end
  end

endmodule // ortc_core

// ==== core/ortc_defines.svh ====
`ifndef ORTC_DEFINES_SVH
`define ORTC_DEFINES_SVH

// Bus addresses, instruction codes and counter values
`define ORTC_ADDR_WR      8'ha0
`define ORTC_ADDR_RD      8'ha1
`define ORTC_CMD_HOLD_ON  8'h11
`define ORTC_CMD_HOLD_OFF 8'h10
`define ORTC_CMD_SLP_ON   8'h21
`define ORTC_CMD_SLP_OFF  8'h20
`define ORTC_CMD_PASS_ON  8'h31
`define ORTC_CMD_PASS_OFF 8'h30
`define ORTC_CMD_FAST_ON  8'h41
`define ORTC_CMD_FAST_OFF 8'h40
`define ORTC_CMD_LOAD     8'h80
`define ORTC_SLEEP_VALUE  24'haaaaaa
`define ORTC_COUNT_RESET  24'h000000

// Avalon register byte offsets
`define ORTC_OFS_STATUS   4'h0
`define ORTC_OFS_COUNT    4'h4
`define ORTC_OFS_CTRL     4'h8

// Status and control register fields
`define ORTC_ST_HOLD      0
`define ORTC_ST_SLEEP     1
`define ORTC_ST_PASS      2
`define ORTC_ST_FAST      3
`define ORTC_ST_FROZEN    4
`define ORTC_ST_POR       5
`define ORTC_CTRL_LOSS_EN 0
`define ORTC_CTRL_RESET   1'b1

// Timing
`define ORTC_CLK_MHZ      250
`define ORTC_POR_MS       10
`define ORTC_OSC_LOSS_US  1000
`define ORTC_OSC_HZ       32768
`define ORTC_PRESCALE     4
`define ORTC_SLOW_S       32
`define ORTC_FAST_S       1
`define ORTC_TICK_HZ      (`ORTC_OSC_HZ / `ORTC_PRESCALE)
`define ORTC_POR_CYCLES   (`ORTC_POR_MS * `ORTC_CLK_MHZ * 1000)
`define ORTC_LOSS_CYCLES  (`ORTC_OSC_LOSS_US * `ORTC_CLK_MHZ)
`define ORTC_SLOW_TICKS   (`ORTC_SLOW_S * `ORTC_TICK_HZ)
`define ORTC_FAST_TICKS   (`ORTC_FAST_S * `ORTC_TICK_HZ)

`endif

// ==== core/ortc_pkg.sv ====
package ortc_pkg;

  typedef enum logic [2:0] {
    ORTC_IDLE,
    ORTC_ADDR,
    ORTC_WDATA,
    ORTC_ACK,
    ORTC_RDATA,
    ORTC_RACK,
    ORTC_IGNORE
  } ortc_bus_st_t;

endpackage

// ==== core/ortc_sync.sv ====
`timescale 1ns/100ps
module ortc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RESET_VAL;
      q      <= RESET_VAL;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // ortc_sync

// ==== sim/ortc_checker.sv ====
`timescale 1ns/100ps
module ortc_checker #(
  parameter int unsigned POR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic osc_enable,
  input wire logic wake_out
);
  int unsigned por_q;
  logic [7:0]  stop_age_q;
  logic        sda_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Counts only the reset release; an oscillator-loss restart is not checked
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      por_q <= 0;
    else if (por_q < POR_CYCLES)
      por_q <= por_q + 1;
  end

  // STOP seen on the raw pins; sleep entry lags it by the synchronisers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_q      <= 1'b1;
      stop_age_q <= 8'hff;
    end
    else
    begin
      sda_q <= sda_in;
      if (scl_in && sda_in && !sda_q)
        stop_age_q <= 8'h00;
      else if (stop_age_q != 8'hff)
        stop_age_q <= stop_age_q + 8'h01;
    end
  end

  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  property p_wait_first;
    $rose(avs_read || avs_write) |-> s_answer;
  endproperty
  property p_wait_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  property p_one_wait;
    (avs_read || avs_write) && !avs_waitrequest |-> $past(avs_waitrequest);
  endproperty
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  property p_por;
    por_q < POR_CYCLES |-> !sda_oe;
  endproperty
  property p_rst_state;
    $fell(rst) |-> osc_enable && !sda_oe && !wake_out;
  endproperty
  property p_sleep_stop;
    $fell(osc_enable) |-> stop_age_q < 8'h10;
  endproperty
  sequence s_ack;
    ##[0:4] sda_oe;
  endsequence
  property p_wake_ack;
    $rose(osc_enable) |-> s_ack;
  endproperty
  property p_oe_steady;
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty

  a_wait_first: assert property (p_wait_first) else $error("no single wait cycle");
  a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
  a_one_wait: assert property (p_one_wait) else $error("answer without wait cycle");
  a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
  a_por: assert property (p_por) else $error("ack during internal reset");
  a_rst_state: assert property (p_rst_state) else $error("bad state at reset");
  a_sleep_stop: assert property (p_sleep_stop) else $error("sleep not at STOP");
  a_wake_ack: assert property (p_wake_ack) else $error("wake outside ack");
  a_oe_steady: assert property (p_oe_steady) else $error("data moved, clock high");
endmodule // ortc_checker

bind ortc_core ortc_checker #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .osc_enable(osc_enable), .wake_out(wake_out)
);

// ==== sim/ortc_i2c_master.sv ====
`timescale 1ns/100ps
module ortc_i2c_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One 160 ns bit; data moves mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    cyc(10);
    sda_low <= ~b;
    cyc(10);
    scl <= 1'b1;
    cyc(10);
    r = sda;
    cyc(10);
  endtask

  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask

  // Serves as repeated START too: the slave may still hold its ack
  task automatic start();
    scl <= 1'b0;
    sda_low <= 1'b0;
    cyc(20);
    scl <= 1'b1;
    cyc(10);
    sda_low <= 1'b1;
    cyc(10);
  endtask

  task automatic stop();
    scl <= 1'b0;
    cyc(10);
    sda_low <= 1'b1;
    cyc(10);
    scl <= 1'b1;
    cyc(10);
    sda_low <= 1'b0;
    cyc(20);
  endtask
endmodule // ortc_i2c_master

// ==== sim/ortc_core_bench.sv ====
`timescale 1ns/100ps
`include "ortc_defines.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module ortc_core_bench;
  localparam int unsigned POR  = 2000;
  localparam int          TICK = 200;
  localparam logic [3:0]  ST   = `ORTC_OFS_STATUS;
  localparam logic [3:0]  CNT  = `ORTC_OFS_COUNT;

  logic        clk           = 1'b0;
  logic        rst           = 1'b1;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        scl;
  logic        sda_low;
  logic        sda_oe;
  logic        osc_enable;
  logic        wake_out;
  logic        osc_in        = 1'b0;
  logic        osc_kill      = 1'b0;
  logic [4:0]  osc_cnt       = 5'h00;
  wire         sda           = ~(sda_low | sda_oe);
  int          miscompares   = 0;
  int          checked       = 0;

  always #2 clk = ~clk;

  // Crystal: 200 ns period, stops while the device asks for sleep
  always @(posedge clk)
  begin
    osc_cnt <= (osc_cnt == 5'h18) ? 5'h00 : osc_cnt + 5'h01;
    if (osc_cnt == 5'h18 && osc_enable && !osc_kill)
      osc_in <= ~osc_in;
  end

  ortc_core #(.POR_CYCLES(POR), .LOSS_CYCLES(500), .SLOW_TICKS(8), .FAST_TICKS(2)) dut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .osc_in(osc_in),
    .osc_enable(osc_enable), .wake_out(wake_out));

  ortc_i2c_master u_mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  task automatic final_report();
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= ~w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic reg_is(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string n);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    `CHK(n, e, q & m)
  endtask

  task automatic send(input logic [7:0] b, input logic nack);
    logic [7:0] q;
    logic       a;
    u_mst.xfer(b, 1'b1, q, a);
    `CHK("ack", nack, a)
  endtask

  task automatic cmd(input logic [7:0] b);
    u_mst.start();
    send(`ORTC_ADDR_WR, 1'b0);
    send(b, 1'b0);
    u_mst.stop();
  endtask

  // Rise of the wake pin, counted in clocks from the call
  task automatic wait_wake(output int n);
    logic p;
    n = 0;
    p = wake_out;
    forever
    begin
      @(posedge clk);
      n++;
      if ((wake_out === 1'b1 && p === 1'b0) || n >= 4000)
        break;
      p = wake_out;
    end
  endtask

  task automatic t_por();
    logic [31:0] q;
    reg_is(ST, 32'h20, 32'h20, "por_busy");
    u_mst.start();
    send(`ORTC_ADDR_WR, 1'b1);
    u_mst.stop();
    repeat (POR) @(posedge clk);
    av(1'b1, ST, 32'hffffffff, q);
    av(1'b1, 4'hc, 32'hffffffff, q);
    reg_is(ST, 32'h3f, 32'h0, "status_rst");
    reg_is(CNT, 32'hffffff, `ORTC_COUNT_RESET, "count_rst");
    reg_is(`ORTC_OFS_CTRL, 32'hffffffff, 32'h1, "ctrl_rst");
    reg_is(4'hc, 32'hffffffff, 32'h0, "unmapped");
  endtask

  task automatic t_modes();
    u_mst.start();
    send(`ORTC_ADDR_WR, 1'b0);
    send(`ORTC_CMD_HOLD_ON, 1'b0);
    send(`ORTC_CMD_LOAD, 1'b0);
    send(8'haa, 1'b0);
    send(8'hbb, 1'b0);
    send(8'hcc, 1'b0);
    send(`ORTC_CMD_FAST_ON, 1'b0);
    u_mst.stop();
    reg_is(CNT, 32'hffffff, 32'haabbcc, "load3");
    reg_is(ST, 32'hf, 32'h9, "hold_fast");
    repeat (4 * TICK) @(posedge clk);
    reg_is(CNT, 32'hffffff, 32'haabbcc, "held");
    cmd(`ORTC_CMD_LOAD);
    reg_is(CNT, 32'hffffff, 32'haabbcc, "load0");
    u_mst.start();
    send(`ORTC_ADDR_WR, 1'b0);
    send(`ORTC_CMD_LOAD, 1'b0);
    send(8'h12, 1'b0);
    u_mst.stop();
    reg_is(CNT, 32'hffffff, 32'h12bbcc, "load1");
    cmd(8'h55);
    reg_is(ST, 32'hf, 32'h9, "unknown");
    reg_is(CNT, 32'hffffff, 32'h12bbcc, "unknown_cnt");
    u_mst.start();
    send(8'hb0, 1'b1);
    send(`ORTC_CMD_FAST_OFF, 1'b1);
    u_mst.stop();
    reg_is(ST, 32'hf, 32'h9, "foreign");
    cmd(`ORTC_CMD_FAST_OFF);
    reg_is(ST, 32'hf, 32'h1, "fast_off");
  endtask

  task automatic t_release();
    int n;
    repeat (300) @(posedge clk);
    cmd(`ORTC_CMD_HOLD_OFF);
    wait_wake(n);
    `CHK("first_inc", 1'b1, n >= 7 * TICK - 100 && n <= 8 * TICK - 80)
    wait_wake(n);
    `CHK("slow_period", 8 * TICK, n)
    reg_is(CNT, 32'hffffff, 32'h12bbce, "counted");
  endtask

  task automatic t_read();
    logic [31:0] v;
    logic [7:0]  q [4];
    logic        a;
    int          n;
    cmd(`ORTC_CMD_FAST_ON);
    wait_wake(n);
    wait_wake(n);
    `CHK("fast_period", 2 * TICK, n)
    av(1'b0, CNT, 32'h0, v);
    u_mst.start();
    send(`ORTC_ADDR_RD, 1'b0);
    for (int i = 0; i < 4; i++)
      u_mst.xfer(8'hff, i == 3, q[i], a);
    u_mst.start();
    reg_is(CNT, 32'hffffff, v + 32'h1, "pending");
    u_mst.stop();
    `CHK("rd_upper", v[23:16], q[0])
    `CHK("rd_middle", v[15:8], q[1])
    `CHK("rd_lower", v[7:0], q[2])
    `CHK("rd_wrap", v[23:16], q[3])
    cmd(`ORTC_CMD_FAST_OFF);
  endtask

  task automatic t_pass();
    cmd(`ORTC_CMD_PASS_ON);
    reg_is(ST, 32'h4, 32'h4, "pass_on");
    repeat (3)
    begin
      @(posedge osc_in);
      repeat (10) @(posedge clk);
      `CHK("wake_hi", 1'b1, wake_out)
      @(negedge osc_in);
      repeat (10) @(posedge clk);
      `CHK("wake_lo", 1'b0, wake_out)
    end
    cmd(`ORTC_CMD_PASS_OFF);
    reg_is(ST, 32'h4, 32'h0, "pass_off");
  endtask

  task automatic t_sleep();
    u_mst.start();
    send(`ORTC_ADDR_WR, 1'b0);
    send(`ORTC_CMD_HOLD_ON, 1'b0);
    send(`ORTC_CMD_LOAD, 1'b0);
    repeat (3) send(8'haa, 1'b0);
    send(`ORTC_CMD_SLP_ON, 1'b0);
    u_mst.stop();
    repeat (20) @(posedge clk);
    `CHK("osc_stop", 1'b0, osc_enable)
    repeat (1000) @(posedge clk);
    reg_is(ST, 32'h23, 32'h3, "asleep");
    reg_is(CNT, 32'hffffff, `ORTC_SLEEP_VALUE, "sleep_cnt");
    u_mst.start();
    send(`ORTC_ADDR_WR, 1'b0);
    send(`ORTC_CMD_SLP_OFF, 1'b0);
    `CHK("osc_run", 1'b1, osc_enable)
    send(`ORTC_CMD_HOLD_OFF, 1'b0);
    u_mst.stop();
    reg_is(ST, 32'h3, 32'h0, "awake");
    osc_kill <= 1'b1;
    repeat (1000) @(posedge clk);
    reg_is(ST, 32'h2f, 32'h20, "loss_reset");
    reg_is(CNT, 32'hffffff, `ORTC_COUNT_RESET, "loss_cnt");
    osc_kill <= 1'b0;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_por();
    t_modes();
    t_release();
    t_read();
    t_pass();
    t_sleep();
    final_report();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule // ortc_core_bench
